// ---- hw/tmr2_consts.svh ----
/*
 * Register offsets, field positions, reset values and event codes of the
 * sixteen-bit capture/reload/baud timer.
 * Assumes inclusion by bare name from design and bench files alike.
 */
`ifndef TMR2_CONSTS_SVH
`define TMR2_CONSTS_SVH

// Word indices as printed, byte address is four times the index.
`define TMR2_IDX_CTRL        8'hc8
`define TMR2_IDX_MODE        8'hc9
`define TMR2_IDX_RELOAD_LO   8'hca
`define TMR2_IDX_RELOAD_HI   8'hcb
`define TMR2_IDX_COUNT_LO    8'hcc
`define TMR2_IDX_COUNT_HI    8'hcd
`define TMR2_IDX_IRQ_STAT    8'hce
`define TMR2_IDX_IRQ_MASK    8'hcf

`define TMR2_ADDR_CTRL       10'h320
`define TMR2_ADDR_MODE       10'h324
`define TMR2_ADDR_RELOAD_LO  10'h328
`define TMR2_ADDR_RELOAD_HI  10'h32c
`define TMR2_ADDR_COUNT_LO   10'h330
`define TMR2_ADDR_COUNT_HI   10'h334
`define TMR2_ADDR_IRQ_STAT   10'h338
`define TMR2_ADDR_IRQ_MASK   10'h33c

// Control register fields.
`define TMR2_B_OVF           7
`define TMR2_B_EXT_FLAG      6
`define TMR2_B_RX_BAUD       5
`define TMR2_B_TX_BAUD       4
`define TMR2_B_EXT_EN        3
`define TMR2_B_RUN           2
`define TMR2_B_CNT_SEL       1
`define TMR2_B_CAP_SEL       0
`define TMR2_CTRL_RESET      8'h00

// Mode register field.
`define TMR2_B_UPDOWN        0

// Interrupt status bits.
`define TMR2_EV_OVF          0
`define TMR2_EV_EXT          1
`define TMR2_EV_CAPTURE      2
`define TMR2_EV_WIDTH        3

`define TMR2_COUNT_ALL_ONES  16'hffff

`endif

// ---- hw/tmr2_pkg.sv ----
/*
 * Types shared by the timer top and its edge detector.
 * Assumes the constants header is compiled alongside.
 */
package tmr2_pkg;
   typedef enum logic [2:0] {
      TMR2_BUS_IDLE = 3'b001,
      TMR2_BUS_ACK  = 3'b010,
      TMR2_BUS_WAIT = 3'b100
   } tmr2_bus_e;

   typedef logic [15:0] tmr2_count_t;
endpackage

// ---- hw/tmr2_edge_if.sv ----
/*
 * Carries the falling-edge strobes of the two timer pins from the edge
 * detector to the timer core.
 * Assumes both ends share the timer clock.
 */
`timescale 1ns/1ns
interface tmr2_edge_if;
   logic count_fall;
   logic trig_fall;
   logic trig_level;
   modport det  (output count_fall, output trig_fall, output trig_level);
   modport core (input count_fall, input trig_fall, input trig_level);
endinterface

// ---- hw/tmr2_edge_det.sv ----
/*
 * Falling-edge detector for the count input pin and the trigger pin.
 * Assumes the pins are already synchronous to the timer clock.
 */
`timescale 1ns/1ns
module tmr2_edge_det
   import tmr2_pkg::*;
(
   input  wire logic  clk_in,     // timer clock
   input  wire logic  rst_n_in,   // synchronous reset, active low
   input  wire logic  count_in,   // count input pin
   input  wire logic  trig_in,    // trigger pin
   tmr2_edge_if.det   edges       // strobes toward the core
);
   typedef struct packed {
      logic count_d;
      logic trig_d;
   } tmr2_det_s;

   tmr2_det_s st_reg;
   tmr2_det_s st_next;

   always_comb begin
      st_next.count_d = count_in;
      st_next.trig_d  = trig_in;
   end

   // Idle high, so a pin held low through reset gives a fall strobe until the first clock after reset.
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         st_reg <= 2'b11;
      end else begin
         st_reg <= st_next;
      end
   end

   assign edges.count_fall = st_reg.count_d & ~count_in;
   assign edges.trig_fall  = st_reg.trig_d & ~trig_in;
   assign edges.trig_level = trig_in;
endmodule

// ---- hw/tmr2_top.sv ----
/*
 * Sixteen-bit timer/counter with auto-reload, capture, up/down counting
 * and baud tick outputs, reached over a classic Wishbone slave.
 * Assumes pins synchronous to CLK_SYS_IN and a single-cycle master.
 */
// Added by the designer: the Wishbone slave port.
`timescale 1ns/1ns
`include "tmr2_consts.svh"

// Functional notes
// - Trigger falling edge captures/reloads, sets event flag
// - Event flag requests interrupt when enabled
// - Up/down mode: event flag gives no interrupt
// - Tx baud select routes overflow to tx
// - Rx baud select routes overflow to rx
// - Baud mode forces auto-reload, ignores capture select
// - Reload select: reload on overflow and trigger
// - Capture select: capture count on trigger edge
// - Counter select clear counts peripheral clock
// - Counter select set counts count-pin falls
// - Control resets to zero, bit writable
// - Counting only while run control set
// - Up overflow: flag, interrupt, load reload value
// - Up/down: trigger high up, low down
// - Down underflow at reload value loads all ones
module tmr2_top
   import tmr2_pkg::*;
#(
   parameter int WB_ADDR_W = 10
) (
   input  wire logic        CLK_SYS_IN,      // system clock, 125 MHz
   input  wire logic        RSTN_IN,         // synchronous reset, low
   input  wire logic [WB_ADDR_W-1:0] WB_ADR_IN, // byte address
   input  wire logic [31:0] WB_DAT_IN,       // write data
   input  wire logic [3:0]  WB_SEL_IN,       // byte lanes
   input  wire logic        WB_WE_IN,        // write enable
   input  wire logic        WB_CYC_IN,       // bus cycle
   input  wire logic        WB_STB_IN,       // strobe
   input  wire logic        COUNT_PIN_IN,    // external count input pin
   input  wire logic        TRIGGER_PIN_IN,  // external trigger pin
   output logic [31:0]      WB_DAT_OUT,      // read data
   output logic             WB_ACK_OUT,      // acknowledge
   output logic             WB_ERR_OUT,      // unmapped address
   output logic             TX_BAUD_TICK_OUT,// transmit baud tick
   output logic             RX_BAUD_TICK_OUT,// receive baud tick
   output logic             IRQ_OUT          // interrupt, level high
);
   initial begin
      if (WB_ADDR_W < 10) begin
         $error("WB_ADDR_W must hold the register addresses");
      end
   end

   typedef struct packed {
      tmr2_bus_e   bus;
      logic [31:0] rdata;
      logic        ack;
      logic        err;
      logic [7:0]  ctrl;
      logic        updown;
      tmr2_count_t reload;
      tmr2_count_t count;
      logic [`TMR2_EV_WIDTH-1:0] stat;
      logic [`TMR2_EV_WIDTH-1:0] mask;
      logic        tx_tick;
      logic        rx_tick;
      logic        irq;
   } tmr2_state_s;

   tmr2_state_s st_reg;
   tmr2_state_s st_next;

   tmr2_edge_if edges ();

   tmr2_edge_det u_edge (
      .clk_in   (CLK_SYS_IN),
      .rst_n_in (RSTN_IN),
      .count_in (COUNT_PIN_IN),
      .trig_in  (TRIGGER_PIN_IN),
      .edges    (edges.det)
   );

   logic                 req;
   logic                 wr_req;
   logic                 rd_req;
   logic [WB_ADDR_W-1:0] adr;
   logic                 mapped;
   logic                 baud_mode;
   logic                 tick;
   logic                 count_up;
   logic                 roll;
   logic                 ext_hit;
   logic                 do_capture;
   logic                 do_reload;
   logic [`TMR2_EV_WIDTH-1:0] ev;
   logic [31:0]          rd_val;
   logic [7:0]           wbyte;

   assign req    = WB_CYC_IN & WB_STB_IN;
   assign adr    = WB_ADR_IN;
   assign wbyte  = WB_DAT_IN[7:0];
   assign mapped = (adr[WB_ADDR_W-1:2] >= `TMR2_IDX_CTRL) &&
                   (adr[WB_ADDR_W-1:2] <= `TMR2_IDX_IRQ_MASK) &&
                   (adr[1:0] == 2'b00);

   always_comb begin
      st_next    = st_reg;
      wr_req     = 1'b0;
      rd_req     = 1'b0;
      rd_val     = 32'h0000_0000;
      ev         = '0;
      baud_mode  = st_reg.ctrl[`TMR2_B_TX_BAUD] |
                   st_reg.ctrl[`TMR2_B_RX_BAUD];
      count_up   = !st_reg.updown || edges.trig_level;
      // Timer source ticks every clock; counter source on pin falls.
      tick = st_reg.ctrl[`TMR2_B_RUN] &&
             (st_reg.ctrl[`TMR2_B_CNT_SEL] ?
              edges.count_fall : 1'b1);
      ext_hit    = st_reg.ctrl[`TMR2_B_EXT_EN] && edges.trig_fall;
      roll       = 1'b0;
      do_capture = 1'b0;
      do_reload  = 1'b0;

      // Bus handshake: one ack (err if unmapped) per request, then a gap cycle.
      st_next.ack = 1'b0;
      st_next.err = 1'b0;
      case (st_reg.bus)
         TMR2_BUS_IDLE: begin
            if (req) begin
               st_next.bus = TMR2_BUS_ACK;
               wr_req = WB_WE_IN & mapped;
               rd_req = ~WB_WE_IN & mapped;
               st_next.ack = mapped;
               st_next.err = ~mapped;
            end
         end
         TMR2_BUS_ACK: begin
            st_next.bus = TMR2_BUS_WAIT;
         end
         TMR2_BUS_WAIT: begin
            if (!req) begin
               st_next.bus = TMR2_BUS_IDLE;
            end
         end
         default: begin
            st_next.bus = TMR2_BUS_IDLE;
         end
      endcase

      // Counting, overflow and underflow.
      if (tick) begin
         if (count_up || baud_mode) begin
            if (st_reg.count == `TMR2_COUNT_ALL_ONES) begin
               roll = 1'b1;
               st_next.count = st_reg.reload;
            end else begin
               st_next.count = st_reg.count + 16'h0001;
            end
         end else begin
            if (st_reg.count == st_reg.reload) begin
               roll = 1'b1;
               st_next.count = `TMR2_COUNT_ALL_ONES;
            end else begin
               st_next.count = st_reg.count - 16'h0001;
            end
         end
      end

      // Capture or reload on a trigger edge.
      if (ext_hit) begin
         if (st_reg.ctrl[`TMR2_B_CAP_SEL] && !baud_mode) begin
            do_capture = 1'b1;
            st_next.reload = st_reg.count;
         end else if (!st_reg.updown) begin
            do_reload = 1'b1;
            st_next.count = st_reg.reload;
         end
      end

      // Overflow only raises the flag outside baud generation.
      st_next.tx_tick = roll & st_reg.ctrl[`TMR2_B_TX_BAUD];
      st_next.rx_tick = roll & st_reg.ctrl[`TMR2_B_RX_BAUD];

      // Software writes; hardware sets below win over clears.
      if (wr_req && WB_SEL_IN[0]) begin
         case (adr[9:0])
            `TMR2_ADDR_CTRL:      st_next.ctrl = wbyte;
            `TMR2_ADDR_MODE:      st_next.updown = wbyte[`TMR2_B_UPDOWN];
            `TMR2_ADDR_RELOAD_LO: st_next.reload[7:0] = wbyte;
            `TMR2_ADDR_RELOAD_HI: st_next.reload[15:8] = wbyte;
            `TMR2_ADDR_COUNT_LO:  st_next.count[7:0] = wbyte;
            `TMR2_ADDR_COUNT_HI:  st_next.count[15:8] = wbyte;
            `TMR2_ADDR_IRQ_MASK:
               st_next.mask = wbyte[`TMR2_EV_WIDTH-1:0];
            default: begin
            end
         endcase
      end

      if (roll && !baud_mode) begin
         st_next.ctrl[`TMR2_B_OVF] = 1'b1;
         ev[`TMR2_EV_OVF] = 1'b1;
      end
      if (do_capture || do_reload) begin
         st_next.ctrl[`TMR2_B_EXT_FLAG] = 1'b1;
         if (!st_reg.updown) begin
            ev[`TMR2_EV_EXT] = 1'b1;
         end
      end
      ev[`TMR2_EV_CAPTURE] = do_capture;

      // Read mux; a status read clears what it returned.
      case (adr[9:0])
         `TMR2_ADDR_CTRL:      rd_val[7:0] = st_reg.ctrl;
         `TMR2_ADDR_MODE:      rd_val[0] = st_reg.updown;
         `TMR2_ADDR_RELOAD_LO: rd_val[7:0] = st_reg.reload[7:0];
         `TMR2_ADDR_RELOAD_HI: rd_val[7:0] = st_reg.reload[15:8];
         `TMR2_ADDR_COUNT_LO:  rd_val[7:0] = st_reg.count[7:0];
         `TMR2_ADDR_COUNT_HI:  rd_val[7:0] = st_reg.count[15:8];
         `TMR2_ADDR_IRQ_STAT:  rd_val[`TMR2_EV_WIDTH-1:0] = st_reg.stat;
         `TMR2_ADDR_IRQ_MASK:  rd_val[`TMR2_EV_WIDTH-1:0] = st_reg.mask;
         default:              rd_val = 32'h0000_0000;
      endcase
      if (rd_req) begin
         st_next.rdata = rd_val;
         if (adr[9:0] == `TMR2_ADDR_IRQ_STAT) begin
            st_next.stat = '0;
         end
      end else if (req && st_reg.bus == TMR2_BUS_IDLE) begin
         st_next.rdata = 32'h0000_0000;
      end
      st_next.stat = st_next.stat | ev;
      st_next.irq  = |(st_next.stat & st_next.mask);
   end

   always_ff @(posedge CLK_SYS_IN) begin
      if (!RSTN_IN) begin
         st_reg.bus     <= TMR2_BUS_IDLE;
         st_reg.rdata   <= 32'h0000_0000;
         st_reg.ack     <= 1'b0;
         st_reg.err     <= 1'b0;
         st_reg.ctrl    <= `TMR2_CTRL_RESET;
         st_reg.updown  <= 1'b0;
         st_reg.reload  <= 16'h0000;
         st_reg.count   <= 16'h0000;
         st_reg.stat    <= '0;
         st_reg.mask    <= '0;
         st_reg.tx_tick <= 1'b0;
         st_reg.rx_tick <= 1'b0;
         st_reg.irq     <= 1'b0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign WB_DAT_OUT       = st_reg.rdata;
   assign WB_ACK_OUT       = st_reg.ack;
   assign WB_ERR_OUT       = st_reg.err;
   assign TX_BAUD_TICK_OUT = st_reg.tx_tick;
   assign RX_BAUD_TICK_OUT = st_reg.rx_tick;
   assign IRQ_OUT          = st_reg.irq;
endmodule

// ---- testbench/tmr2_top_properties.sv ----
/* Checker of bus answers, baud tick gating and interrupt masking.
   Assumes a master that holds each request until it is answered. */
`timescale 1ns/1ns
`include "tmr2_consts.svh"
module tmr2_top_properties #(parameter int WB_ADDR_W = 10) (
   input wire logic                 CLK_SYS_IN,       // clock
   input wire logic                 RSTN_IN,          // reset
   input wire logic [WB_ADDR_W-1:0] WB_ADR_IN,        // address
   input wire logic [31:0]          WB_DAT_IN,        // write data
   input wire logic [3:0]           WB_SEL_IN,        // lanes
   input wire logic                 WB_WE_IN,         // write
   input wire logic                 WB_CYC_IN,        // cycle
   input wire logic                 WB_STB_IN,        // strobe
   input wire logic [31:0]          WB_DAT_OUT,       // read data
   input wire logic                 WB_ACK_OUT,       // ack
   input wire logic                 WB_ERR_OUT,       // error
   input wire logic                 TX_BAUD_TICK_OUT, // tx tick
   input wire logic                 RX_BAUD_TICK_OUT, // rx tick
   input wire logic                 IRQ_OUT           // interrupt
);
   logic [7:0] ctrl_reg;
   logic [2:0] mask_reg;
   logic       req;
   logic       mapped;
   logic       wr_done;
   assign req = WB_CYC_IN && WB_STB_IN;
   assign mapped = WB_ADR_IN[9:5] == 5'h19 && WB_ADR_IN[1:0] == 2'h0;
   assign wr_done = WB_WE_IN && WB_SEL_IN[0];
   // Shadows load at the taking edge, the same edge the design writes.
   always_ff @(posedge CLK_SYS_IN) begin
      if (!RSTN_IN) begin
         ctrl_reg <= 8'h00;
         mask_reg <= 3'h0;
      end else if ($rose(req) && wr_done &&
                   WB_ADR_IN == `TMR2_ADDR_CTRL) begin
         ctrl_reg <= WB_DAT_IN[7:0];
      end else if ($rose(req) && wr_done &&
                   WB_ADR_IN == `TMR2_ADDR_IRQ_MASK) begin
         mask_reg <= WB_DAT_IN[2:0];
      end
   end
   default clocking @(posedge CLK_SYS_IN); endclocking
   default disable iff (!RSTN_IN);
   a_ack_one_cycle: assert property (
      WB_ACK_OUT |=> !WB_ACK_OUT && !WB_ERR_OUT) else $error("ack held");
   a_answer_next: assert property (
      $rose(req) |=> WB_ACK_OUT != WB_ERR_OUT) else $error("no answer");
   a_err_unmapped: assert property (
      $rose(req) |=> WB_ERR_OUT != $past(mapped)) else $error("bad err");
   a_answer_cause: assert property (
      WB_ACK_OUT || WB_ERR_OUT |-> $past(req)) else $error("stray ack");
   a_read_upper: assert property (
      WB_ACK_OUT && !WB_WE_IN |-> WB_DAT_OUT[31:8] == 24'h0)
      else $error("upper read bits set");
   a_tx_gate: assert property (
      TX_BAUD_TICK_OUT |-> $past(ctrl_reg[4]) && $past(ctrl_reg[2]))
      else $error("tx tick while not selected");
   a_rx_gate: assert property (
      RX_BAUD_TICK_OUT |-> $past(ctrl_reg[5]) && $past(ctrl_reg[2]))
      else $error("rx tick while not selected");
   a_irq_masked: assert property (
      IRQ_OUT |-> mask_reg != 3'h0) else $error("irq with all masked");
endmodule

bind tmr2_top tmr2_top_properties #(.WB_ADDR_W(WB_ADDR_W)) u_props (
   .CLK_SYS_IN(CLK_SYS_IN), .RSTN_IN(RSTN_IN), .WB_ADR_IN(WB_ADR_IN),
   .WB_DAT_IN(WB_DAT_IN), .WB_SEL_IN(WB_SEL_IN), .WB_WE_IN(WB_WE_IN),
   .WB_CYC_IN(WB_CYC_IN), .WB_STB_IN(WB_STB_IN), .WB_DAT_OUT(WB_DAT_OUT),
   .WB_ACK_OUT(WB_ACK_OUT), .WB_ERR_OUT(WB_ERR_OUT),
   .TX_BAUD_TICK_OUT(TX_BAUD_TICK_OUT), .RX_BAUD_TICK_OUT(RX_BAUD_TICK_OUT),
   .IRQ_OUT(IRQ_OUT));

// ---- testbench/tmr2_link_model.sv ----
/* Far side of the timer: drives the count and trigger pins and tallies
   baud ticks. Assumes the timer samples the pins on rising edges. */
`timescale 1ns/1ns
module tmr2_link_model (
   input  wire logic clk_in,     // clock
   input  wire logic tx_tick_in, // tx tick
   input  wire logic rx_tick_in, // rx tick
   output logic      count_out,  // count pin
   output logic      trig_out    // trigger pin
);
   int tx_n = 0;
   int rx_n = 0;
   initial count_out = 1'b1;
   initial trig_out = 1'b1;
   always @(posedge clk_in) begin
      if (tx_tick_in) tx_n <= tx_n + 1;
      if (rx_tick_in) rx_n <= rx_n + 1;
   end
   // Two clocks low and three high between pulses, so every fall is seen exactly once.
   task automatic pulse(input int n);
      repeat (n) begin
         @(posedge clk_in) count_out <= 1'b0;
         repeat (2) @(posedge clk_in);
         count_out <= 1'b1;
         repeat (2) @(posedge clk_in);
      end
   endtask
   task automatic trig(input logic v);
      @(posedge clk_in) trig_out <= v;
      repeat (3) @(posedge clk_in);
   endtask
endmodule

// ---- testbench/tmr2_top_test.sv ----
/* Bench for the timer: registers, counting, capture, reload, up/down,
   baud ticks and interrupt. Assumes one-cycle bus answers. */
`timescale 1ns/1ns
`include "tmr2_consts.svh"
module tmr2_top_test;
   logic        clk, rstn, we, cyc, stb, cpin, tpin;
   logic        ack, err, tx, rx, irq, berr;
   logic [9:0]  adr;
   logic [3:0]  sel;
   logic [31:0] wdat, dout, rdat;
   int          err_count = 0;
   int          checked = 0;
   int          cycles = 0;
   int          t0, r0;
   tmr2_top dut (
      .CLK_SYS_IN(clk), .RSTN_IN(rstn), .WB_ADR_IN(adr), .WB_DAT_IN(wdat),
      .WB_SEL_IN(sel), .WB_WE_IN(we), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
      .COUNT_PIN_IN(cpin), .TRIGGER_PIN_IN(tpin), .WB_DAT_OUT(dout),
      .WB_ACK_OUT(ack), .WB_ERR_OUT(err), .TX_BAUD_TICK_OUT(tx),
      .RX_BAUD_TICK_OUT(rx), .IRQ_OUT(irq));
   tmr2_link_model far (.clk_in(clk), .tx_tick_in(tx), .rx_tick_in(rx),
      .count_out(cpin), .trig_out(tpin));
   initial clk = 1'b0;
   always #4 clk = ~clk;
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         err_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic wb(input logic w, input logic [9:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {24'h0, d};
      do begin
         @(posedge clk);
         n++;
      end while (!ack && !err && n < 40);
      rdat = dout;
      berr = err;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      wb(1'b1, a, d);
   endtask
   task automatic rc(input logic [9:0] a, input logic [7:0] e);
      wb(1'b0, a, 8'h00);
      chk(rdat, {24'h0, e});
   endtask
   task automatic give_verdict();
      $display("checks %0d errors %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         give_verdict();
      end
   end
   initial begin
      rstn = 1'b0;
      {we, cyc, stb, adr, wdat} = '0;
      sel = 4'h1;
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      rc(`TMR2_ADDR_CTRL, 8'h00);
      sel <= 4'he;
      wr(`TMR2_ADDR_CTRL, 8'hff);
      sel <= 4'h1;
      rc(`TMR2_ADDR_CTRL, 8'h00);
      wb(1'b0, 10'h300, 8'h00);
      chk(berr, 1'b1);
      wr(`TMR2_ADDR_CTRL, 8'h0b);
      rc(`TMR2_ADDR_CTRL, 8'h0b);
      wr(`TMR2_ADDR_COUNT_LO, 8'h05);
      far.pulse(2);
      rc(`TMR2_ADDR_COUNT_LO, 8'h05);
      wr(`TMR2_ADDR_CTRL, 8'h0f);
      far.pulse(3);
      rc(`TMR2_ADDR_COUNT_LO, 8'h08);
      wr(`TMR2_ADDR_IRQ_MASK, 8'h02);
      far.trig(1'b0);
      rc(`TMR2_ADDR_RELOAD_LO, 8'h08);
      chk(irq, 1'b1);
      rc(`TMR2_ADDR_CTRL, 8'h4f);
      rc(`TMR2_ADDR_IRQ_STAT, 8'h06);
      repeat (2) @(posedge clk);
      chk(irq, 1'b0);
      rc(`TMR2_ADDR_CTRL, 8'h4f);
      far.trig(1'b1);
      wr(`TMR2_ADDR_CTRL, 8'h0e);
      wr(`TMR2_ADDR_COUNT_LO, 8'h20);
      far.trig(1'b0);
      rc(`TMR2_ADDR_COUNT_LO, 8'h08);
      rc(`TMR2_ADDR_IRQ_STAT, 8'h02);
      wr(`TMR2_ADDR_MODE, 8'h01);
      far.trig(1'b1);
      wr(`TMR2_ADDR_COUNT_LO, 8'h09);
      far.pulse(1);
      rc(`TMR2_ADDR_COUNT_LO, 8'h0a);
      far.trig(1'b0);
      far.pulse(3);
      rc(`TMR2_ADDR_COUNT_HI, 8'hff);
      rc(`TMR2_ADDR_COUNT_LO, 8'hff);
      chk(irq, 1'b0);
      rc(`TMR2_ADDR_IRQ_STAT, 8'h01);
      wr(`TMR2_ADDR_MODE, 8'h00);
      wr(`TMR2_ADDR_CTRL, 8'h00);
      wr(`TMR2_ADDR_RELOAD_HI, 8'h34);
      wr(`TMR2_ADDR_COUNT_LO, 8'hf0);
      wr(`TMR2_ADDR_IRQ_MASK, 8'h01);
      wr(`TMR2_ADDR_CTRL, 8'h04);
      r0 = 0;
      while (!irq && r0 < 100) begin
         @(posedge clk);
         r0++;
      end
      chk(irq, 1'b1);
      rc(`TMR2_ADDR_CTRL, 8'h84);
      wr(`TMR2_ADDR_CTRL, 8'h00);
      rc(`TMR2_ADDR_COUNT_HI, 8'h34);
      rc(`TMR2_ADDR_IRQ_STAT, 8'h01);
      wr(`TMR2_ADDR_RELOAD_HI, 8'hff);
      wr(`TMR2_ADDR_RELOAD_LO, 8'hf0);
      for (int i = 0; i < 2; i++) begin
         wr(`TMR2_ADDR_COUNT_HI, 8'hff);
         wr(`TMR2_ADDR_COUNT_LO, 8'hf0);
         t0 = far.tx_n;
         r0 = far.rx_n;
         wr(`TMR2_ADDR_CTRL, (i == 1) ? 8'h25 : 8'h15);
         repeat (64) @(posedge clk);
         rc(`TMR2_ADDR_CTRL, (i == 1) ? 8'h25 : 8'h15);
         rc(`TMR2_ADDR_COUNT_HI, 8'hff);
         wr(`TMR2_ADDR_CTRL, 8'h00);
         chk(far.tx_n != t0, i == 0);
         chk(far.rx_n != r0, i == 1);
      end
      give_verdict();
   end
endmodule
